// ==== lsi_pkg.sv ====
// Constants, register map and field layout of the logger status indicator block
package lsi_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Logging lamp pulse interval
  localparam int unsigned LOG_PERIOD_MS = 2000;
  localparam int unsigned LOG_ON_MS = 50;
  // Warning lamp blink, a free choice since no rate is given
  localparam int unsigned RED_PERIOD_MS = 1000;
  localparam int unsigned RED_ON_MS = 50;
  localparam int unsigned LOG_PERIOD_CYC = (LOG_PERIOD_MS * 1000) / CLK_PERIOD_NS * 1000;
  localparam int unsigned LOG_ON_CYC = (LOG_ON_MS * 1000) / CLK_PERIOD_NS * 1000;
  localparam int unsigned RED_PERIOD_CYC = (RED_PERIOD_MS * 1000) / CLK_PERIOD_NS * 1000;
  localparam int unsigned RED_ON_CYC = (RED_ON_MS * 1000) / CLK_PERIOD_NS * 1000;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MODULES = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WRAP = 1;
  localparam int CTRL_CHEM_LSB = 2;
  localparam int CTRL_REFRESH = 4;
  localparam int CTRL_CLR_HIST = 5;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int ST_MEM_LOW = 0;
  localparam int ST_BATT_LOW = 1;
  localparam int ST_POL_BAD = 2;
  localparam int ST_FAIL_NOW = 3;
  localparam int ST_FAIL_PAST = 4;
  localparam int ST_RECORDING = 5;
  localparam int ST_SCAN_BUSY = 6;
  localparam int ST_MEM_FULL = 7;

  // ****************************************
  // Interrupt bits (status and mask share layout)
  // ****************************************
  localparam int IRQ_MEM_LOW = 0;
  localparam int IRQ_BATT_LOW = 1;
  localparam int IRQ_SENS_FAIL = 2;
  localparam int IRQ_MEM_FULL = 3;
  localparam int IRQ_SCAN_DONE = 4;
  localparam int IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

  // ****************************************
  // Battery chemistry and thresholds (pack millivolts, eight cells)
  // ****************************************
  typedef enum logic [1:0] {
    CHEM_ALKALINE = 2'b00,
    CHEM_ENHANCED = 2'b01,
    CHEM_LITHIUM = 2'b10,
    CHEM_SPARE = 2'b11
  } lsi_chem_e;

  localparam logic [15:0] ALK_FULL_MV = 16'h2ee0;
  localparam logic [15:0] ALK_EMPTY_MV = 16'h1f40;
  localparam logic [15:0] ENH_FULL_MV = 16'h3070;
  localparam logic [15:0] ENH_EMPTY_MV = 16'h1f40;
  localparam logic [15:0] LITH_FULL_MV = 16'h3200;
  localparam logic [15:0] LITH_EMPTY_MV = 16'h2260;
  // A quarter of the usable span above empty is the 25% capacity point
  localparam logic [15:0] ALK_LOW_MV = ALK_EMPTY_MV + ((ALK_FULL_MV - ALK_EMPTY_MV) >> 2);
  localparam logic [15:0] ENH_LOW_MV = ENH_EMPTY_MV + ((ENH_FULL_MV - ENH_EMPTY_MV) >> 2);
  localparam logic [15:0] LITH_LOW_MV = LITH_EMPTY_MV + ((LITH_FULL_MV - LITH_EMPTY_MV) >> 2);

  // ****************************************
  // Rescan state machine
  // ****************************************
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_REQ = 2'b01,
    SCAN_WAIT = 2'b11
  } lsi_scan_e;

endpackage

// ==== lsi_sync.sv ====
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module lsi_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= async_i[i];
          sync_q <= meta_q;
        end
      end
      assign sync_o[i] = sync_q;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== lsi_blink.sv ====
// Free-running blink generator: a short high window once per period
`timescale 1ns/1ps
`default_nettype none
module lsi_blink #(
  parameter int unsigned PERIOD = 20,
  parameter int unsigned ON = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Blink phase
  output logic on_o,
  output logic tick_o
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb
  begin
    if (cnt_q >= 32'(PERIOD - 1))
      cnt_d = 32'h0;
    else
      cnt_d = cnt_q + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_d;
  end

  assign on_o = (cnt_q < 32'(ON));
  assign tick_o = (cnt_q == 32'h0);

endmodule
`default_nettype wire

// ==== lsi_top.sv ====
// Status lamp logic of the data logger with an APB register slave
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - With wrapping off, the memory lamp blinks once free data memory is below a quarter of capacity.
// - With wrapping off, recording goes on after the memory warning and stops only when no location is free.
// - With wrapping on, the memory lamp stays dark whatever the memory fill.
// - The battery lamp blinks when the estimated capacity is below a quarter of full.
// - The battery lamp also blinks when reversed cell polarity is detected, whatever the estimate.
// - A battery warning never stops recording.
// - The host sets the chemistry at launch and the battery estimate is taken against that chemistry.
// - The sensor lamp blinks on a present or past link failure and stays set until the host writes the history clear bit.
// - A past failure that has cleared while logging goes on blinks the sensor lamp with the logging lamp.
// - While any module is not answering only the sensor lamp blinks and the others stay dark.
// - On a host refresh request the device rescans the sensor network and reports the modules found.
// - While recording the logging lamp pulses once every two seconds.
module lsi_top #(
  parameter int NMOD = 8,
  parameter int MEM_W = 20,
  parameter int unsigned LOG_PERIOD = lsi_pkg::LOG_PERIOD_CYC,
  parameter int unsigned LOG_ON = lsi_pkg::LOG_ON_CYC,
  parameter int unsigned RED_PERIOD = lsi_pkg::RED_PERIOD_CYC,
  parameter int unsigned RED_ON = lsi_pkg::RED_ON_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory and battery measures from same-clock logic
  input wire logic [MEM_W-1:0] mem_free,
  input wire logic [MEM_W-1:0] mem_size,
  input wire logic [15:0] batt_mv,
  // Pins
  input wire logic batt_pol_bad,
  input wire logic [NMOD-1:0] mod_fail,
  // Sensor network scan handshake, same clock
  output logic scan_req,
  input wire logic scan_done,
  input wire logic [NMOD-1:0] scan_present,
  // Recording gate
  output logic rec_enable,
  // Lamps and interrupt
  output logic lamp_log,
  output logic lamp_mem,
  output logic lamp_batt,
  output logic lamp_sens,
  output logic irq
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NMOD:0] pins_s;
  logic pol_bad_s;
  logic [NMOD-1:0] fail_s;

  lsi_sync #(
    .W(NMOD + 1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i({batt_pol_bad, mod_fail}),
    .sync_o(pins_s)
  );

  assign pol_bad_s = pins_s[NMOD];
  assign fail_s = pins_s[NMOD-1:0];

  // ****************************************
  // Blink phases
  // ****************************************
  logic red_on;
  logic log_on;

  lsi_blink #(
    .PERIOD(RED_PERIOD),
    .ON(RED_ON)
  ) u_red (
    .pclk(pclk),
    .presetn(presetn),
    .on_o(red_on),
    .tick_o()
  );

  lsi_blink #(
    .PERIOD(LOG_PERIOD),
    .ON(LOG_ON)
  ) u_log (
    .pclk(pclk),
    .presetn(presetn),
    .on_o(log_on),
    .tick_o()
  );

  // ****************************************
  // Register bus decode
  // ****************************************
  localparam int IRQ_W_L = lsi_pkg::IRQ_W;
  logic [3:0] ctrl_q;
  logic [IRQ_W_L-1:0] irq_stat_q;
  logic [IRQ_W_L-1:0] irq_mask_q;
  logic [NMOD-1:0] present_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic [7:0] status_w;
  logic setup;
  logic wr;
  logic hit;
  logic wr_ctrl;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign wr_ctrl = wr && (paddr == lsi_pkg::OFF_CTRL);

  always_comb
  begin
    hit = 1'b1;
    rd_d = 32'h0;
    case (paddr)
      lsi_pkg::OFF_CTRL: rd_d[3:0] = ctrl_q;
      lsi_pkg::OFF_STATUS: rd_d[7:0] = status_w;
      lsi_pkg::OFF_MODULES: rd_d[NMOD-1:0] = present_q;
      lsi_pkg::OFF_IRQ_STAT: rd_d[IRQ_W_L-1:0] = irq_stat_q;
      lsi_pkg::OFF_IRQ_MASK: rd_d[IRQ_W_L-1:0] = irq_mask_q;
      default: hit = 1'b0;
    endcase
  end

  // Read data captured in setup so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (setup)
      prdata_q <= rd_d;
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ****************************************
  // Control and mask registers
  // ****************************************
  logic run;
  logic wrap;
  lsi_pkg::lsi_chem_e chem;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= lsi_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= lsi_pkg::IRQ_RST;
    else if (wr && (paddr == lsi_pkg::OFF_IRQ_MASK))
      irq_mask_q <= pwdata[IRQ_W_L-1:0];
  end

  assign run = ctrl_q[lsi_pkg::CTRL_RUN];
  assign wrap = ctrl_q[lsi_pkg::CTRL_WRAP];
  assign chem = lsi_pkg::lsi_chem_e'(ctrl_q[lsi_pkg::CTRL_CHEM_LSB +: 2]);

  // ****************************************
  // Memory and battery conditions
  // ****************************************
  logic mem_low_q;
  logic mem_full_q;
  logic batt_low_q;
  logic rec_q;
  logic [15:0] low_mv;

  always_comb
  begin
    case (chem)
      lsi_pkg::CHEM_ENHANCED: low_mv = lsi_pkg::ENH_LOW_MV;
      lsi_pkg::CHEM_LITHIUM: low_mv = lsi_pkg::LITH_LOW_MV;
      default: low_mv = lsi_pkg::ALK_LOW_MV;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_low_q <= 1'b0;
      mem_full_q <= 1'b0;
    end
    else
    begin
      mem_low_q <= !wrap && ({mem_free, 2'b00} < {2'b00, mem_size});
      mem_full_q <= !wrap && (mem_free == '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      batt_low_q <= 1'b0;
    else
      batt_low_q <= (batt_mv < low_mv) || pol_bad_s;
  end

  // Battery state deliberately has no say here, the supply ends it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rec_q <= 1'b0;
    else
      rec_q <= run && !(!wrap && (mem_free == '0));
  end

  assign rec_enable = rec_q;

  // ****************************************
  // Sensor failure history
  // ****************************************
  logic fail_now_q;
  logic hist_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_now_q <= 1'b0;
    else
      fail_now_q <= |fail_s;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hist_q <= 1'b0;
    else if (fail_now_q)
      hist_q <= 1'b1;
    else if (wr_ctrl && pwdata[lsi_pkg::CTRL_CLR_HIST])
      hist_q <= 1'b0;
  end

  // ****************************************
  // Network rescan
  // ****************************************
  lsi_pkg::lsi_scan_e scan_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan_q <= lsi_pkg::SCAN_IDLE;
    else
    begin
      case (scan_q)
        lsi_pkg::SCAN_IDLE:
          if (wr_ctrl && pwdata[lsi_pkg::CTRL_REFRESH])
            scan_q <= lsi_pkg::SCAN_REQ;
        lsi_pkg::SCAN_REQ:
          scan_q <= lsi_pkg::SCAN_WAIT;
        lsi_pkg::SCAN_WAIT:
          if (scan_done)
            scan_q <= lsi_pkg::SCAN_IDLE;
        default:
          scan_q <= lsi_pkg::SCAN_IDLE;
      endcase
    end
  end

  assign scan_req = (scan_q == lsi_pkg::SCAN_REQ);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      present_q <= '0;
    else if (scan_q == lsi_pkg::SCAN_WAIT && scan_done)
      present_q <= scan_present;
  end

  assign status_w = {mem_full_q, scan_q != lsi_pkg::SCAN_IDLE, rec_q, hist_q, fail_now_q,
                     pol_bad_s, batt_low_q, mem_low_q};

  // ****************************************
  // Interrupts
  // ****************************************
  logic [IRQ_W_L-1:0] ev_lvl;
  logic [IRQ_W_L-1:0] ev_lvl_q;
  logic [IRQ_W_L-1:0] ev_set;
  logic [IRQ_W_L-1:0] ev_clr;

  assign ev_lvl = {1'b0, mem_full_q, fail_now_q, batt_low_q, mem_low_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_lvl_q <= lsi_pkg::IRQ_RST;
    else
      ev_lvl_q <= ev_lvl;
  end

  always_comb
  begin
    ev_set = ev_lvl & ~ev_lvl_q;
    ev_set[lsi_pkg::IRQ_SCAN_DONE] = (scan_q == lsi_pkg::SCAN_WAIT) && scan_done;
    ev_clr = '0;
    if (wr && (paddr == lsi_pkg::OFF_IRQ_STAT))
      ev_clr = pwdata[IRQ_W_L-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= lsi_pkg::IRQ_RST;
    else
      irq_stat_q <= (irq_stat_q & ~ev_clr) | ev_set;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // Lamp drivers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lamp_log <= 1'b0;
      lamp_mem <= 1'b0;
      lamp_batt <= 1'b0;
      lamp_sens <= 1'b0;
    end
    else
    begin
      lamp_log <= !fail_now_q && rec_q && log_on;
      lamp_mem <= !fail_now_q && mem_low_q && red_on;
      lamp_batt <= !fail_now_q && batt_low_q && red_on;
      if (fail_now_q)
        lamp_sens <= red_on;
      else if (hist_q && rec_q)
        lamp_sens <= log_on;
      else
        lamp_sens <= hist_q && red_on;
    end
  end

endmodule
`default_nettype wire

// ==== lsi_sva.sv ====
// Assertion checker for the logger status lamp block
`timescale 1ns/1ps
`default_nettype none
module lsi_sva #(
  parameter int NMOD = 8,
  parameter int MEM_W = 20,
  parameter int unsigned LOG_PERIOD = 40,
  parameter int unsigned LOG_ON = 4,
  parameter int RED_ON = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Measures and pins
  input wire logic [MEM_W-1:0] mem_free,
  input wire logic [MEM_W-1:0] mem_size,
  input wire logic [NMOD-1:0] mod_fail,
  // Watched outputs
  input wire logic scan_req,
  input wire logic rec_enable,
  input wire logic lamp_log,
  input wire logic lamp_mem,
  input wire logic lamp_batt,
  input wire logic lamp_sens
);
  // ****************************************
  // Shadow of the launch settings
  // ****************************************
  logic run_q;
  logic wrap_q;
  logic rfw_q;
  logic log_q;
  logic [1:0] low_q;
  logic [31:0] since_q;
  logic [31:0] batt_on_q;
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == lsi_pkg::OFF_CTRL;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 1'b0;
      wrap_q <= 1'b0;
      rfw_q <= 1'b0;
      log_q <= 1'b0;
      low_q <= 2'h0;
      since_q <= 32'hffffffff;
      batt_on_q <= 32'h0;
    end
    else
    begin
      rfw_q <= ctrl_wr && pwdata[lsi_pkg::CTRL_REFRESH];
      run_q <= ctrl_wr ? pwdata[lsi_pkg::CTRL_RUN] : run_q;
      wrap_q <= ctrl_wr ? pwdata[lsi_pkg::CTRL_WRAP] : wrap_q;
      low_q <= {low_q[0], !wrap_q && ({mem_free, 2'h0} < {2'h0, mem_size})};
      log_q <= lamp_log;
      batt_on_q <= lamp_batt ? batt_on_q + 32'h1 : 32'h0;
      since_q <= (lamp_log && !log_q) ? 32'h1 : (since_q == 32'hffffffff ? since_q : since_q + 32'h1);
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  req_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(scan_req) |-> rfw_q) else $error("scan request without refresh write");
  req_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    scan_req |=> !scan_req) else $error("scan request longer than one cycle");
  rec_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run_q && (wrap_q || mem_free != '0))[*3] |-> rec_enable) else $error("recording stopped early");
  rec_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wrap_q && mem_free == '0)[*3] |-> !rec_enable) else $error("recording with memory full");
  wrap_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_q && $past(wrap_q, 3) |-> !lamp_mem) else $error("memory lamp lit with wrapping");
  mem_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    lamp_mem |-> low_q[1]) else $error("memory lamp without low memory");
  fail_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|mod_fail)[*6] |-> !lamp_log && !lamp_mem && !lamp_batt) else $error("other lamp lit during failure");
  log_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    lamp_log && !log_q |-> since_q >= LOG_PERIOD - LOG_ON + 1) else $error("logging pulses too close");
  // Counted, not a delay range, since the on window may run to millions of cycles
  batt_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    lamp_batt |-> batt_on_q < 32'(RED_ON)) else $error("battery lamp pulse too long");
endmodule
bind lsi_top lsi_sva #(.NMOD(NMOD), .MEM_W(MEM_W), .LOG_PERIOD(LOG_PERIOD), .LOG_ON(LOG_ON), .RED_ON(RED_ON)) sva_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .mem_free(mem_free), .mem_size(mem_size), .mod_fail(mod_fail), .scan_req(scan_req),
  .rec_enable(rec_enable), .lamp_log(lamp_log), .lamp_mem(lamp_mem), .lamp_batt(lamp_batt), .lamp_sens(lamp_sens));
`default_nettype wire

// ==== lsi_net_model.sv ====
// Sensor network model answering rescan requests
`timescale 1ns/1ps
`default_nettype none
module lsi_net_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scan handshake
  input wire logic scan_req,
  output logic scan_done,
  output logic [7:0] scan_present,
  // Bench control
  input wire logic [7:0] map,
  input wire logic [7:0] delay
);
  // ****************************************
  // Rescan answer
  // ****************************************
  logic busy_q;
  logic [7:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      cnt_q <= 8'h0;
      scan_done <= 1'b0;
      scan_present <= 8'h0;
    end
    else
    begin
      scan_done <= 1'b0;
      // Outside an answer the map toggles so a stale sample shows
      scan_present <= ~scan_present;
      if (scan_req)
      begin
        busy_q <= 1'b1;
        cnt_q <= delay;
      end
      else if (busy_q && cnt_q == 8'h0)
      begin
        busy_q <= 1'b0;
        scan_done <= 1'b1;
        scan_present <= map;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 8'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb_logger_status_indicator_logic.sv ====
// Self-checking bench for the logger status lamp block
`timescale 1ns/1ps
`default_nettype none
module tb_logger_status_indicator_logic;
  // ****************************************
  // Signals and bench model state
  // ****************************************
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0, sc_map = 8'h0, sc_delay = 8'h0, mod_fail = 8'h0, scan_present;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, scan_req, scan_done, rec_enable, lamp_log, lamp_mem, lamp_batt, lamp_sens, irq;
  logic [19:0] mem_free = 20'd1000, mem_size = 20'd1000;
  logic [15:0] batt_mv = 16'hffff;
  logic batt_pol_bad = 1'b0, run = 1'b0, wrap = 1'b0, pol = 1'b0, fnow = 1'b0, hist = 1'b0;
  logic [1:0] chem = 2'h0;
  int failures = 0, n_tests = 0, n_req = 0, c[4], same;
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (scan_req === 1'b1) n_req++;
  lsi_top #(.LOG_PERIOD(40), .LOG_ON(4), .RED_PERIOD(20), .RED_ON(2)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_free(mem_free),
    .mem_size(mem_size), .batt_mv(batt_mv), .batt_pol_bad(batt_pol_bad), .mod_fail(mod_fail),
    .scan_req(scan_req), .scan_done(scan_done), .scan_present(scan_present), .rec_enable(rec_enable),
    .lamp_log(lamp_log), .lamp_mem(lamp_mem), .lamp_batt(lamp_batt), .lamp_sens(lamp_sens), .irq(irq));
  lsi_net_model net_u (.pclk(pclk), .presetn(presetn), .scan_req(scan_req), .scan_done(scan_done),
    .scan_present(scan_present), .map(sc_map), .delay(sc_delay));
  // ****************************************
  // Tasks and reference model
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_ctrl(input logic rf, input logic clr);
    apb(1'b1, lsi_pkg::OFF_CTRL, {26'h0, clr, rf, chem, wrap, run});
  endtask
  task automatic lamps();
    c = '{0, 0, 0, 0};
    same = 0;
    repeat (40)
    begin
      @(negedge pclk);
      c[0] += lamp_log;
      c[1] += lamp_mem;
      c[2] += lamp_batt;
      c[3] += lamp_sens;
      same += (lamp_sens === lamp_log);
    end
  endtask
  function automatic int thr(input logic [1:0] k);
    if (k == 2'h1) return lsi_pkg::ENH_EMPTY_MV + (lsi_pkg::ENH_FULL_MV - lsi_pkg::ENH_EMPTY_MV) / 4;
    if (k == 2'h2) return lsi_pkg::LITH_EMPTY_MV + (lsi_pkg::LITH_FULL_MV - lsi_pkg::LITH_EMPTY_MV) / 4;
    return lsi_pkg::ALK_EMPTY_MV + (lsi_pkg::ALK_FULL_MV - lsi_pkg::ALK_EMPTY_MV) / 4;
  endfunction
  function automatic logic [31:0] st_exp();
    logic [31:0] s;
    s = 32'h0;
    s[lsi_pkg::ST_MEM_LOW] = !wrap && 4 * int'(mem_free) < int'(mem_size);
    s[lsi_pkg::ST_BATT_LOW] = int'(batt_mv) < thr(chem) || pol;
    s[lsi_pkg::ST_POL_BAD] = pol;
    s[lsi_pkg::ST_FAIL_NOW] = fnow;
    s[lsi_pkg::ST_FAIL_PAST] = hist;
    s[lsi_pkg::ST_MEM_FULL] = !wrap && mem_free == 20'h0;
    s[lsi_pkg::ST_RECORDING] = run && !s[lsi_pkg::ST_MEM_FULL];
    return s;
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(50 * 30000);
    failures++;
    close_out();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] s;
    void'($urandom(32'h42ed6c3f));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (s[i]) if (i < 5) begin apb(1'b0, 8'h4 * i, 32'h0); chk(rd, 32'h0); end
    apb(1'b0, 8'h14, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h18, 32'hffffffff);
    chk(err, 1'b1);
    $display("test reset and map done");
    for (int i = 0; i < 16; i++)
    begin
      run = (i % 7 != 3);
      wrap = i[2];
      chem = i[1:0];
      pol = (i % 6 == 5);
      wr_ctrl(1'b0, 1'b0);
      @(posedge pclk);
      mem_size <= 20'd1000;
      mem_free <= (i % 5 == 0) ? 20'h0 : 20'(248 + $urandom_range(0, 4));
      batt_mv <= 16'(thr(chem) - 2 + $urandom_range(0, 4));
      batt_pol_bad <= pol;
      repeat (8) @(posedge pclk);
      apb(1'b0, lsi_pkg::OFF_STATUS, 32'h0);
      s = st_exp();
      chk(rd, s);
      lamps();
      chk(c[1], s[lsi_pkg::ST_MEM_LOW] ? 4 : 0);
      chk(c[2], s[lsi_pkg::ST_BATT_LOW] ? 4 : 0);
      chk(c[0], s[lsi_pkg::ST_RECORDING] ? 4 : 0);
    end
    $display("test lamp conditions done");
    apb(1'b1, lsi_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b1, lsi_pkg::OFF_IRQ_STAT, 32'h1f);
    apb(1'b0, lsi_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    @(posedge pclk);
    batt_mv <= 16'hffff;
    batt_pol_bad <= 1'b0;
    pol = 1'b0;
    repeat (8) @(posedge pclk);
    batt_mv <= 16'h0;
    repeat (8) @(posedge pclk);
    apb(1'b0, lsi_pkg::OFF_IRQ_STAT, 32'h0);
    chk({irq, rd[30:0]}, 32'h2);
    apb(1'b1, lsi_pkg::OFF_IRQ_MASK, 32'h2);
    @(negedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, lsi_pkg::OFF_IRQ_STAT, 32'h2);
    @(negedge pclk);
    apb(1'b0, lsi_pkg::OFF_IRQ_STAT, 32'h0);
    chk({irq, rd[30:0]}, 32'h0);
    $display("test interrupt done");
    run = 1'b1;
    wrap = 1'b1;
    wr_ctrl(1'b0, 1'b0);
    @(posedge pclk);
    mod_fail <= 8'h1 << $urandom_range(0, 7);
    fnow = 1'b1;
    hist = 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, lsi_pkg::OFF_STATUS, 32'h0);
    chk(rd, st_exp());
    lamps();
    chk(c[0] + c[1] + c[2], 0);
    chk(c[3], 4);
    @(posedge pclk);
    mod_fail <= 8'h0;
    fnow = 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, lsi_pkg::OFF_STATUS, 32'h0);
    chk(rd, st_exp());
    lamps();
    chk(same, 40);
    chk(c[3], 4);
    wr_ctrl(1'b0, 1'b1);
    hist = 1'b0;
    repeat (8) @(posedge pclk);
    lamps();
    chk(c[3], 0);
    $display("test sensor failure done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge pclk);
      sc_map <= 8'($urandom);
      sc_delay <= k ? 8'd12 : 8'd0;
      wr_ctrl(1'b1, 1'b0);
      if (k == 1) wr_ctrl(1'b1, 1'b0);
      for (int w = 0; w < 40; w++)
      begin
        apb(1'b0, lsi_pkg::OFF_STATUS, 32'h0);
        if (rd[lsi_pkg::ST_SCAN_BUSY] === 1'b0) break;
      end
      apb(1'b0, lsi_pkg::OFF_MODULES, 32'h0);
      chk(rd, {24'h0, sc_map});
      chk(n_req, k + 1);
      apb(1'b0, lsi_pkg::OFF_IRQ_STAT, 32'h0);
      chk(rd[lsi_pkg::IRQ_SCAN_DONE], 1'b1);
      apb(1'b1, lsi_pkg::OFF_IRQ_STAT, 32'h10);
    end
    apb(1'b0, lsi_pkg::OFF_CTRL, 32'h0);
    chk(rd, {28'h0, chem, wrap, run});
    $display("test rescan done");
    close_out();
  end
endmodule
`default_nettype wire
